/* File: hdl/threshold_alert_defines.svh */
`ifndef THRESHOLD_ALERT_DEFINES_SVH
`define THRESHOLD_ALERT_DEFINES_SVH
// ----------------------------------------
// alert response address, queue setting codes and timing constants
// ----------------------------------------
`define ALERT_RESP_ADDR 7'h0c
`define QUEUE_ONE 2'h0
`define QUEUE_TWO 2'h1
`define QUEUE_FOUR 2'h2
`define QUEUE_OFF 2'h3
`define CLK_MHZ 100
`define RDY_PULSE_US 8
`define RDY_PULSE_CYC (`RDY_PULSE_US * `CLK_MHZ)
`define IDLE_TIMEOUT_MS 25
`define IDLE_TIMEOUT_CYC (`IDLE_TIMEOUT_MS * 1000 * `CLK_MHZ)
`endif

/* File: hdl/threshold_alert_pkg.sv */
package threshold_alert_pkg;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [2:0] {
    BUS_IDLE = 3'h0,
    BUS_ADDR = 3'h1,
    BUS_ADDR_ACK = 3'h3,
    BUS_TX = 3'h2,
    BUS_TX_ACK = 3'h6,
    BUS_SKIP = 3'h7
  } bus_state_type;
  typedef logic signed [11:0] sample_type;
endpackage

/* File: hdl/pin_sync.sv */
`timescale 1ns/1ns
module pin_sync (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic pinIn,
  output logic pinOut
);
  logic stage1_r;
  // ----------------------------------------
  // two-flop synchroniser, resets to bus idle level
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      stage1_r <= 1'b1;
      pinOut <= 1'b1;
    end else begin
      stage1_r <= pinIn;
      pinOut <= stage1_r;
    end
  end
endmodule

/* File: hdl/threshold_alert_comparator.sv */
`timescale 1ns/1ns
`include "threshold_alert_defines.svh"
// What this block does
// [R1] traditional mode: set above high, clear below low
// [R2] window mode: alert outside either threshold
// [R3] latch holds alert once asserted
// [R4] latch cleared by result read or response
// [R5] polarity picks active level, low default
// [R6] queue needs 1/2/4 hits, or disables
// [R7] high msb 1, low msb 0: ready mode
// [R8] continuous ready: 8 us pulse per conversion
// [R9] single-shot ready: assert at conversion end
// [R10] cleared alert re-arms on later excursion
// [R11] open-drain alert, released when disabled
// [R12] answer alert response with own address
// [R13] lowest address wins; loser keeps alert
// [R14] window status bit: 1 high, 0 low
// [R15] bus idle over 25 ms times out
// [R16] slave only, clock is input only
// [R17] lines only pulled low, never driven high
// [R18] bytes of eight; start and stop detection
// [R19] host sends address plus direction bit
// [R20] ninth clock low acknowledges byte
// [R21] start while active is repeated start
// [R22] host picks single-shot period
// [R23] comparisons are signed twos complement
// [R24] in-bounds result restarts queue counter
module threshold_alert_comparator #(
  parameter int IDLE_TIMEOUT_CYCLES = `IDLE_TIMEOUT_CYC,
  parameter int PULSE_CYCLES = `RDY_PULSE_CYC
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic convDone,
  input wire threshold_alert_pkg::sample_type convResult,
  input wire threshold_alert_pkg::sample_type highThresh,
  input wire threshold_alert_pkg::sample_type lowThresh,
  input wire logic continuousMode,
  input wire logic windowMode,
  input wire logic alert_latch_enable,
  input wire logic alert_polarity,
  input wire logic [1:0] alert_queue_setting,
  input wire logic resultRead,
  input wire logic [6:0] slaveAddr,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  output logic alertOut,
  output logic alertOe,
  output logic alertActive,
  output logic busTimeout
);
  import threshold_alert_pkg::*;

  initial begin
    if (IDLE_TIMEOUT_CYCLES < 2 || PULSE_CYCLES < 1)
      $error("threshold_alert_comparator: counts too small");
  end

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic sclSync;
  logic sdaSync;
  pin_sync sclSyncInst (.mclk(mclk), .reset_n(reset_n), .pinIn(sclIn), .pinOut(sclSync)); // [R16]
  pin_sync sdaSyncInst (.mclk(mclk), .reset_n(reset_n), .pinIn(sdaIn), .pinOut(sdaSync));

  // ----------------------------------------
  // comparator decode
  // ----------------------------------------
  logic aboveHigh;
  logic belowLow;
  logic readyMode;
  logic queueOff;
  logic outOfBounds;
  logic [2:0] queueNeed;
  assign aboveHigh = convResult > highThresh; // [R23]
  assign belowLow = convResult < lowThresh; // [R23]
  assign readyMode = highThresh[11] && !lowThresh[11]; // [R7]
  assign queueOff = alert_queue_setting == `QUEUE_OFF; // [R6]
  // window counts both excursions; traditional counts only the upper one
  assign outOfBounds = windowMode ? (aboveHigh || belowLow) : aboveHigh; // [R1] [R2]
  assign queueNeed = (alert_queue_setting == `QUEUE_ONE) ? 3'h1 :
                     (alert_queue_setting == `QUEUE_TWO) ? 3'h2 : 3'h4; // [R6]

  // ----------------------------------------
  // queue counter and comparator state
  // ----------------------------------------
  logic [2:0] hitCount_r;
  logic [2:0] hitCount_nxt;
  logic compAlert_r;
  logic compAlert_nxt;
  logic statusHigh_r;
  logic statusHigh_nxt;
  logic trip;
  logic clearReq;
  logic inBounds;
  assign inBounds = !aboveHigh && !belowLow;
  assign hitCount_nxt = !outOfBounds ? 3'h0 :
                        (hitCount_r < queueNeed) ? hitCount_r + 3'h1 : hitCount_r; // [R24]
  assign trip = convDone && outOfBounds && (hitCount_nxt >= queueNeed); // [R6]

  // latch clear always wins over nothing, but a trip in the same cycle re-asserts
  always_comb begin
    compAlert_nxt = compAlert_r;
    if (clearReq && alert_latch_enable)
      compAlert_nxt = 1'b0; // [R4]
    if (convDone && !alert_latch_enable && !windowMode && belowLow)
      compAlert_nxt = 1'b0; // [R1]
    if (convDone && !alert_latch_enable && windowMode && inBounds)
      compAlert_nxt = 1'b0; // [R2]
    if (trip)
      compAlert_nxt = 1'b1; // [R10]
    if (queueOff || readyMode)
      compAlert_nxt = 1'b0; // [R6]
  end
  assign statusHigh_nxt = trip ? aboveHigh : statusHigh_r; // [R14]

  // comparator registers; latching holds compAlert since only clears above drop it
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      hitCount_r <= 3'h0;
      compAlert_r <= 1'b0;
      statusHigh_r <= 1'b0;
    end else begin
      if (convDone)
        hitCount_r <= hitCount_nxt; // [R24]
      compAlert_r <= compAlert_nxt; // [R3]
      statusHigh_r <= statusHigh_nxt;
    end
  end

  // ----------------------------------------
  // conversion-ready output
  // ----------------------------------------
  logic [31:0] pulseCount_r;
  logic readyLevel_r;
  logic pulseLive;
  assign pulseLive = pulseCount_r != 32'h0;
  // the pulse count lives in a counter, so a new conversion restarts it
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pulseCount_r <= 32'h0;
      readyLevel_r <= 1'b0;
    end else begin
      if (convDone && continuousMode)
        pulseCount_r <= 32'(PULSE_CYCLES); // [R8]
      else if (pulseLive)
        pulseCount_r <= pulseCount_r - 32'h1;
      if (convDone && !continuousMode)
        readyLevel_r <= 1'b1; // [R9]
      else if (resultRead || continuousMode)
        readyLevel_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // i2c edge and condition detection
  // ----------------------------------------
  logic sclPrev_r;
  logic sdaPrev_r;
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;
  assign sclRise = sclSync && !sclPrev_r;
  assign sclFall = !sclSync && sclPrev_r;
  assign startSeen = sclSync && sclPrev_r && sdaPrev_r && !sdaSync; // [R18] [R21]
  assign stopSeen = sclSync && sclPrev_r && !sdaPrev_r && sdaSync; // [R18]

  // ----------------------------------------
  // alert response slave
  // ----------------------------------------
  bus_state_type busState_r;
  bus_state_type busState_nxt;
  logic [3:0] bitCount_r;
  logic [7:0] shift_r;
  logic [7:0] txByte_r;
  logic txDrive_r;
  logic lostArb_r;
  logic [31:0] idleCount_r;
  logic idleExpired;
  logic addrMatch;
  logic byteDone;
  assign byteDone = bitCount_r == 4'h8;
  // host's address plus read bit, against the fixed response address
  assign addrMatch = shift_r == {`ALERT_RESP_ADDR, 1'b1}; // [R12] [R19]
  assign idleExpired = idleCount_r >= 32'(IDLE_TIMEOUT_CYCLES); // [R15]
  assign clearReq = resultRead ||
                    (busState_r == BUS_TX_ACK && sclRise && !lostArb_r); // [R4] [R13]

  // state transitions; start restarts the address phase unless the idle timer has expired
  always_comb begin
    busState_nxt = busState_r;
    if (stopSeen || idleExpired)
      busState_nxt = BUS_IDLE; // [R15] [R21]
    else if (startSeen)
      busState_nxt = BUS_ADDR; // [R21]
    else if (sclFall) begin
      unique case (busState_r)
        BUS_IDLE: busState_nxt = BUS_IDLE;
        BUS_ADDR: busState_nxt = byteDone ?
          ((addrMatch && compAlert_r && alert_latch_enable) ? BUS_ADDR_ACK : BUS_SKIP) :
          BUS_ADDR; // [R12]
        BUS_ADDR_ACK: busState_nxt = BUS_TX;
        BUS_TX: busState_nxt = (byteDone || lostArb_r) ? BUS_TX_ACK : BUS_TX;
        BUS_TX_ACK: busState_nxt = BUS_SKIP;
        BUS_SKIP: busState_nxt = BUS_SKIP;
        default: busState_nxt = BUS_IDLE;
      endcase
    end
  end

  // bit shifting, arbitration and drive of the data line
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      busState_r <= BUS_IDLE;
      bitCount_r <= 4'h0;
      shift_r <= 8'h00;
      txByte_r <= 8'h00;
      txDrive_r <= 1'b0;
      lostArb_r <= 1'b0;
      sclPrev_r <= 1'b1;
      sdaPrev_r <= 1'b1;
    end else begin
      busState_r <= busState_nxt;
      // previous levels start at the idle level so no false edge follows reset
      sclPrev_r <= sclSync;
      sdaPrev_r <= sdaSync;
      if (startSeen) begin
        bitCount_r <= 4'h0;
        lostArb_r <= 1'b0;
      end else if (sclRise && busState_r != BUS_IDLE) begin
        shift_r <= {shift_r[6:0], sdaSync}; // [R18]
        bitCount_r <= byteDone ? 4'h1 : bitCount_r + 4'h1;
        // we sent a one but the line reads low: a lower address is winning
        if (busState_r == BUS_TX && txByte_r[7] && !sdaSync)
          lostArb_r <= 1'b1; // [R13]
      end
      if (busState_r == BUS_ADDR_ACK && sclFall) begin
        txByte_r <= {slaveAddr, statusHigh_r}; // [R12] [R14]
        bitCount_r <= 4'h0;
      end else if (busState_r == BUS_TX && sclFall)
        txByte_r <= {txByte_r[6:0], 1'b1};
      // drive low only; a one is simply releasing the line
      if (busState_nxt == BUS_ADDR_ACK)
        txDrive_r <= 1'b1; // [R20]
      else if (busState_r == BUS_ADDR_ACK && sclFall)
        txDrive_r <= !slaveAddr[6]; // [R17]
      else if (busState_r == BUS_TX && sclFall && !lostArb_r && !byteDone)
        txDrive_r <= !txByte_r[6];
      else if (busState_nxt != BUS_TX)
        txDrive_r <= 1'b0;
      else if (lostArb_r)
        txDrive_r <= 1'b0; // [R13]
    end
  end

  // idle timer: counts while no bus edge arrives in an active transfer
  always_ff @(posedge mclk) begin
    if (!reset_n)
      idleCount_r <= 32'h0;
    else if (busState_r == BUS_IDLE || sclRise || sclFall || startSeen)
      idleCount_r <= 32'h0;
    else if (!idleExpired)
      idleCount_r <= idleCount_r + 32'h1; // [R15]
  end

  // ----------------------------------------
  // pin outputs, all registered
  // ----------------------------------------
  logic assertNow;
  assign assertNow = queueOff ? 1'b0 :
                     readyMode ? (pulseLive || readyLevel_r) : compAlert_r; // [R7]
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      alertOut <= 1'b0;
      alertOe <= 1'b0;
      alertActive <= 1'b0;
      sdaOut <= 1'b0;
      sdaOe <= 1'b0;
      busTimeout <= 1'b0;
    end else begin
      alertActive <= assertNow;
      alertOut <= 1'b0; // [R11]
      // open-drain: pull low when the pin level is to read low
      alertOe <= assertNow ? !alert_polarity : alert_polarity && !queueOff; // [R5] [R11]
      sdaOut <= 1'b0; // [R17]
      sdaOe <= txDrive_r;
      busTimeout <= idleExpired;
    end
  end
endmodule

/* File: bench/alert_checker_sva.sv */
`timescale 1ns/1ns
// ------------------------------
// alert pin and bus checker
// ------------------------------
module alert_checker import threshold_alert_pkg::*; #(
  parameter int IDLE_TIMEOUT_CYCLES = 200,
  parameter int PULSE_CYCLES = 20
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic convDone,
  input wire sample_type convResult,
  input wire sample_type highThresh,
  input wire sample_type lowThresh,
  input wire logic continuousMode,
  input wire logic windowMode,
  input wire logic alert_latch_enable,
  input wire logic alert_polarity,
  input wire logic [1:0] alert_queue_setting,
  input wire logic resultRead,
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic alertOe,
  input wire logic alertActive,
  input wire logic busTimeout
);
  int idleCnt;
  int highCnt;
  logic sclLast;
  logic sdaLast;
  logic busy;
  logic cmpMode;
  logic q1;
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // ready mode overrides the comparator, so comparator checks skip it
  assign cmpMode = !(highThresh[11] && !lowThresh[11]);
  assign q1 = cmpMode && alert_queue_setting == 2'h0;
  // raw pin quiet time inside a frame; runs ahead of the design's synchroniser
  always_ff @(posedge mclk) begin
    sclLast <= sclIn;
    sdaLast <= sdaIn;
    highCnt <= alertActive ? highCnt + 1 : 0;
    if (!reset_n || busTimeout || (sclIn && sclLast && !sdaLast && sdaIn)) begin
      busy <= 1'b0;
      idleCnt <= 0;
    end else if (sclIn && sclLast && sdaLast && !sdaIn) begin
      busy <= 1'b1;
      idleCnt <= 0;
    end else begin
      idleCnt <= (!busy || sclIn != sclLast) ? 0 : idleCnt + 1;
    end
  end
  a_trip_high: assert property (q1 && convDone && convResult > highThresh |-> ##2 alertActive)
    else $error("alert missed a high excursion");
  a_window_low: assert property (q1 && windowMode && convDone && convResult < lowThresh
    |-> ##2 alertActive) else $error("alert missed a low excursion");
  a_trad_hold: assert property (q1 && !windowMode && alertActive && convDone && !resultRead
    && convResult >= lowThresh |-> ##2 alertActive) else $error("alert left too early");
  a_read_clears: assert property (cmpMode && alert_latch_enable && resultRead && !convDone
    |-> ##[1:2] !alertActive) else $error("read left latch set");
  a_queue_off: assert property ((alert_queue_setting == 2'h3) [*3] |-> !alertActive)
    else $error("alert active while disabled");
  a_pin_level: assert property ((alert_queue_setting != 2'h3 && $stable(alertActive)
    && $stable(alert_polarity)) [*3] |-> alertOe == (alertActive != alert_polarity))
    else $error("alert pin level wrong");
  a_sda_pull_only: assert property (!sdaOut) else $error("sda driven high");
  a_ready_width: assert property (!cmpMode && continuousMode && $fell(alertActive)
    |-> highCnt >= PULSE_CYCLES - 1 && highCnt <= PULSE_CYCLES + 1)
    else $error("ready pulse width wrong");
  a_timeout_late: assert property (busy |-> idleCnt <= IDLE_TIMEOUT_CYCLES + 8)
    else $error("bus timeout missing");
  a_timeout_early: assert property ($rose(busTimeout) |-> busy && idleCnt >= IDLE_TIMEOUT_CYCLES)
    else $error("bus timeout too early");
  c_ready: cover property (!cmpMode && $fell(alertActive));
  c_timeout: cover property ($rose(busTimeout));
  c_latched: cover property (alert_latch_enable && alertActive && resultRead);
endmodule
bind threshold_alert_comparator alert_checker #(.IDLE_TIMEOUT_CYCLES(IDLE_TIMEOUT_CYCLES),
  .PULSE_CYCLES(PULSE_CYCLES)) chk (.*);

/* File: bench/smbus_host_model.sv */
`timescale 1ns/1ns
// ------------------------------
// smbus host with a rival slave
// ------------------------------
module smbus_host_model (
  output logic sclLine,
  output logic sdaPull,
  input wire logic sdaLine,
  input wire logic [7:0] rivalByte,
  input wire logic rivalOn
);
  // idle bus: clock stands high between frames
  initial begin
    sclLine = 1'b1;
    sdaPull = 1'b0;
  end
  // one slot; data moves only while the clock is low
  task slot(input logic hostBit, input logic rivalBit, output logic seen);
    #40 sdaPull = !hostBit || (rivalOn && !rivalBit);
    #40 sclLine = 1'b1;
    #40 seen = sdaLine;
    #40 sclLine = 1'b0;
  endtask
  // alert response: start, command byte, ack, byte back, nack, stop
  task alertResp(output logic [7:0] got, output logic ack);
    logic seen;
    logic [7:0] cmd;
    cmd = 8'h19;
    sdaPull = 1'b1;
    #80 sclLine = 1'b0;
    for (int i = 7; i >= 0; i--) slot(cmd[i], 1'b1, seen);
    slot(1'b1, 1'b1, seen);
    ack = !seen;
    for (int i = 7; i >= 0; i--) begin
      slot(1'b1, rivalByte[i], seen);
      got[i] = seen;
    end
    slot(1'b1, 1'b1, seen);
    #40 sdaPull = 1'b1;
    #40 sclLine = 1'b1;
    #80 sdaPull = 1'b0;
    #80;
  endtask
  // start a frame, clock one bit, then leave both lines high with no stop
  task hang;
    sdaPull = 1'b1;
    #80 sclLine = 1'b0;
    #40 sdaPull = 1'b0;
    #40 sclLine = 1'b1;
  endtask
endmodule

/* File: bench/tb_top.sv */
`timescale 1ns/1ns
// ------------------------------
// comparator testbench
// ------------------------------
module tb_top;
  import threshold_alert_pkg::*;
  localparam int IDLE_CYC = 200;
  // row: window, polarity, result, expected active, expected pin pull
  typedef struct packed {logic win; logic pol; sample_type res; logic act; logic oe;} row_type;
  row_type rows [10] = '{16'h0323, 16'h0003, 16'h3ce0, 16'h3ce0, 16'hbce3,
    16'h8000, 16'h8323, 16'h8000, 16'hc322, 16'hc001};
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic convDone = 1'b0;
  sample_type convResult = 12'h000;
  sample_type highThresh = 12'h064;
  sample_type lowThresh = 12'hf9c;
  logic continuousMode = 1'b1;
  logic windowMode = 1'b0;
  logic alert_latch_enable = 1'b0;
  logic alert_polarity = 1'b0;
  logic [1:0] alert_queue_setting = 2'h0;
  logic resultRead = 1'b0;
  logic [6:0] slaveAddr = 7'h48;
  logic [7:0] rivalByte = 8'h81;
  logic rivalOn = 1'b0;
  logic sclIn, hostPull, sdaOut, sdaOe, alertOut, alertOe, alertActive, busTimeout, ack;
  logic [7:0] got;
  int failCount = 0;
  int samplesChecked = 0;
  wire sdaIn = !(sdaOe || hostPull);
  threshold_alert_comparator #(.IDLE_TIMEOUT_CYCLES(IDLE_CYC), .PULSE_CYCLES(20)) dut (.*);
  smbus_host_model host (.sclLine(sclIn), .sdaPull(hostPull), .sdaLine(sdaIn),
    .rivalByte(rivalByte), .rivalOn(rivalOn));
  always #5 mclk = ~mclk;
  task ck(input logic [7:0] g, input logic [7:0] e);
    samplesChecked++;
    if (g !== e) begin
      failCount++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // one conversion, then look at the alert once it has settled
  task step(input sample_type r, input logic a, input logic o);
    @(negedge mclk);
    convDone = 1'b1;
    convResult = r;
    @(negedge mclk);
    convDone = 1'b0;
    repeat (3) @(negedge mclk);
    ck(8'({alertActive, alertOe}), 8'({a, o}));
  endtask
  task readResult;
    @(negedge mclk);
    resultRead = 1'b1;
    @(negedge mclk);
    resultRead = 1'b0;
    repeat (3) @(negedge mclk);
  endtask
  task wrapUp;
    $display("checks %0d, mismatches %0d", samplesChecked, failCount);
    if (failCount == 0 && samplesChecked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // watchdog sized well past the whole sequence
  initial begin
    #500000;
    failCount++;
    wrapUp;
  end
  // table first, then queue, latch, response, ready and timeout cases
  initial begin
    repeat (12) @(negedge mclk);
    ck(8'({alertActive, alertOe, sdaOe}), 8'h00);
    reset_n = 1'b1;
    foreach (rows[i]) begin
      windowMode = rows[i].win;
      alert_polarity = rows[i].pol;
      step(rows[i].res, rows[i].act, rows[i].oe);
    end
    windowMode = 1'b0;
    alert_polarity = 1'b0;
    alert_queue_setting = 2'h1;
    step(12'h0c8, 1'b0, 1'b0);
    step(12'h000, 1'b0, 1'b0);
    step(12'h0c8, 1'b0, 1'b0);
    step(12'h0c8, 1'b1, 1'b1);
    step(12'hf38, 1'b0, 1'b0);
    alert_queue_setting = 2'h2;
    repeat (3) step(12'h0c8, 1'b0, 1'b0);
    step(12'h0c8, 1'b1, 1'b1);
    alert_queue_setting = 2'h3;
    step(12'h0c8, 1'b0, 1'b0);
    alert_queue_setting = 2'h0;
    alert_latch_enable = 1'b1;
    step(12'hf38, 1'b0, 1'b0);
    step(12'h0c8, 1'b1, 1'b1);
    step(12'hf38, 1'b1, 1'b1);
    readResult;
    ck(8'({alertActive, alertOe}), 8'h00);
    windowMode = 1'b1;
    step(12'h0c8, 1'b1, 1'b1);
    host.alertResp(got, ack);
    ck(8'(ack), 8'h01);
    ck(got, {slaveAddr, 1'b1});
    ck(8'({alertActive, alertOe}), 8'h00);
    step(12'hf38, 1'b1, 1'b1);
    rivalOn = 1'b1;
    host.alertResp(got, ack);
    ck(got, rivalByte);
    ck(8'({alertActive, alertOe}), 8'h03);
    rivalOn = 1'b0;
    host.alertResp(got, ack);
    ck(got, {slaveAddr, 1'b0});
    ck(8'({alertActive, alertOe}), 8'h00);
    highThresh = 12'h800;
    lowThresh = 12'h000;
    step(12'h000, 1'b1, 1'b1);
    repeat (30) @(negedge mclk);
    ck(8'({alertActive, alertOe}), 8'h00);
    continuousMode = 1'b0;
    step(12'h000, 1'b1, 1'b1);
    repeat (30) @(negedge mclk);
    ck(8'({alertActive, alertOe}), 8'h03);
    readResult;
    ck(8'({alertActive, alertOe}), 8'h00);
    // the timeout flag stands two cycles, so watch for it edge by edge
    host.hang;
    for (int i = 0; i < IDLE_CYC + 20 && busTimeout !== 1'b1; i++) @(negedge mclk);
    ck(8'(busTimeout), 8'h01);
    wrapUp;
  end
endmodule
